/* File: common/flash_front_pkg.sv */
// constants, types and register map shared by the flash serial front end
// assumes a 250 MHz system clock and a 32-bit apb register port

package flash_front_pkg;

    // ----------------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int BUSY_TIME_NS = 400;
    localparam int BUSY_CYCLES = BUSY_TIME_NS / CLK_PERIOD_NS;

    // ----------------------------------------------------------------------
    // protocol selection
    // ----------------------------------------------------------------------
    typedef enum logic [1:0] {PROTO_EXT, PROTO_DUAL, PROTO_QUAD} proto_t;

    localparam int EV_DUAL_BIT = 6;
    localparam int EV_QUAD_BIT = 7;
    localparam int NV_DUAL_BIT = 2;
    localparam int NV_QUAD_BIT = 3;
    localparam logic [7:0] EVCFG_RESET = 8'hff;
    localparam logic [15:0] NVCFG_RESET = 16'hffff;

    // ----------------------------------------------------------------------
    // serial commands
    // ----------------------------------------------------------------------
    localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] CMD_READ_STATUS = 8'h05;
    localparam logic [7:0] CMD_READ_FLAGS = 8'h70;
    localparam logic [7:0] CMD_WRITE_EVCFG = 8'h61;
    localparam logic [7:0] CMD_READ_EVCFG = 8'h65;
    localparam logic [7:0] CMD_WRITE_NVCFG = 8'hb1;
    localparam logic [7:0] CMD_PROGRAM = 8'h02;
    localparam logic [7:0] CMD_ERASE = 8'hd8;
    localparam logic [3:0] ADDR_BYTES = 4'h3;
    localparam logic [3:0] RESCUE_ONES = 4'h8;
    localparam logic [3:0] RESCUE_FAIL = 4'hf;
    localparam int FIFO_DEPTH = 4;
    localparam int DATA_W = 8;

    // ----------------------------------------------------------------------
    // apb register map
    // ----------------------------------------------------------------------
    localparam logic [7:0] REG_NVCFG = 8'h00;
    localparam logic [7:0] REG_CTRL = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam int CTRL_BOOT_BIT = 0;
    localparam int CTRL_CLR_OVR_BIT = 1;
    localparam int ST_PROTO_LSB = 0;
    localparam int ST_BUSY_BIT = 2;
    localparam int ST_WEL_BIT = 3;
    localparam int ST_VOLSEL_BIT = 4;
    localparam int ST_ACCEL_BIT = 5;
    localparam int ST_OVERRUN_BIT = 6;
    localparam int ST_EFF_LSB = 8;
    localparam int ST_EVCFG_LSB = 16;

endpackage

/* File: hw/byte_fifo.sv */
// small flip-flop fifo with valid/ready on both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps

module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wrPtr;
        logic [PW-1:0] rdPtr;
        logic [CW-1:0] count;
    } fifo_t;

    fifo_t st;
    fifo_t next_st;
    logic push;
    logic pop;

    assign inReady = (st.count != CW'(DEPTH));
    assign outValid = (st.count != '0);
    assign outData = st.mem[st.rdPtr];
    assign push = inValid & inReady;
    assign pop = outValid & outReady;

    // ----------------------------------------------------------------------
    // pointers wrap explicitly so depth need not be a power of two
    // ----------------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wrPtr] = inData;
            next_st.wrPtr = (st.wrPtr == PW'(DEPTH - 1)) ? '0 : st.wrPtr + 1'b1;
        end
        if (pop) begin
            next_st.rdPtr = (st.rdPtr == PW'(DEPTH - 1)) ? '0 : st.rdPtr + 1'b1;
        end
        if (push && !pop) begin
            next_st.count = st.count + 1'b1;
        end else if (pop && !push) begin
            next_st.count = st.count - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule // byte_fifo

/* File: hw/flash_front.sv */
// serial front end of a multi-line flash: protocol select, command decode, apb port
// assumes pins arrive asynchronously and the serial clock is far slower than clk
//
// Functional notes
// - every input bit is captured on a rising serial clock edge
// - output bits change on falling serial clock edges
// - serial clock may idle low or high; both work
// - both clock idle levels work in single, dual and quad protocols
// - data lines are driven only while selected; otherwise released
// - default protocol: command on line 0, single-line address and data
// - volatile write with bit7 one, bit6 zero selects dual at once
// - volatile write with bit7 zero selects quad at once
// - volatile choice reverts at boot, rescue sequence, or new volatile write
// - nonvolatile bit3 one, bit2 zero boots into dual until set back to one
// - nonvolatile bit3 zero boots into quad until set back to one
// - quad falls back to single-line while accelerated program or erase runs
// - quad resumes once the accelerating supply pin goes low
// - boot loads working setup from nonvolatile copy; volatile writes act at once
// - status bit0 reads one while a write, program or erase is busy
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps

module flash_front
    import flash_front_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sclkPin,
    input wire logic selectN,
    input wire logic [3:0] ioIn,
    output logic [3:0] ioOut,
    output logic [3:0] ioDriveN,
    input wire logic vppPin,
    output logic [DATA_W-1:0] progData,
    output logic progValid,
    input wire logic progReady
);
    typedef enum logic [2:0] {PH_CMD, PH_ARG, PH_DATA, PH_OUT, PH_IGNORE} phase_t;

    typedef struct packed {
        logic sclkMeta;
        logic sclkSync;
        logic sclkPrev;
        logic selMeta;
        logic selSync;
        logic [3:0] ioMeta;
        logic [3:0] ioSync;
        logic vppMeta;
        logic vppSync;
        phase_t phase;
        logic [7:0] cmd;
        logic [3:0] bitCnt;
        logic [3:0] byteCnt;
        logic [7:0] shiftIn;
        logic [7:0] outShift;
        logic [3:0] outCnt;
        logic [3:0] ioOut;
        logic [3:0] ioDriveN;
        logic [3:0] rescueCnt;
        proto_t proto;
        logic volSel;
        logic [7:0] evcfg;
        logic [15:0] nvcfg;
        logic [7:0] nvLow;
        logic wel;
        logic busy;
        logic [15:0] busyCnt;
        logic accelHold;
        logic workPend;
        logic pushValid;
        logic [7:0] pushData;
        logic overrun;
        logic [31:0] prdata;
        logic pslverr;
    } front_t;

    front_t st;
    front_t next_st;
    logic fifoInReady;

    // ----------------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------------
    function automatic proto_t evProto(input logic [7:0] v);
        if (!v[EV_QUAD_BIT]) begin
            return PROTO_QUAD;
        end else if (!v[EV_DUAL_BIT]) begin
            return PROTO_DUAL;
        end
        return PROTO_EXT;
    endfunction

    function automatic proto_t nvProto(input logic [15:0] v);
        if (!v[NV_QUAD_BIT]) begin
            return PROTO_QUAD;
        end else if (!v[NV_DUAL_BIT]) begin
            return PROTO_DUAL;
        end
        return PROTO_EXT;
    endfunction

    function automatic logic [7:0] readSource(input front_t s);
        unique case (s.cmd)
            CMD_READ_STATUS: return {6'h00, s.wel, s.busy};
            CMD_READ_FLAGS: return {~s.busy, 7'h00};
            default: return s.evcfg;
        endcase
    endfunction

    // ----------------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------------
    always_comb begin
        logic rise;
        logic fall;
        logic doneByte;
        logic [7:0] inByte;
        logic [3:0] lanes;
        proto_t effProto;
        rise = 1'b0;
        fall = 1'b0;
        doneByte = 1'b0;
        inByte = 8'h00;
        lanes = 4'h1;
        effProto = st.proto;
        next_st = st;

        // two flops on every pin before any logic looks at it
        next_st.sclkMeta = sclkPin;
        next_st.sclkSync = st.sclkMeta;
        next_st.sclkPrev = st.sclkSync;
        next_st.selMeta = selectN;
        next_st.selSync = st.selMeta;
        next_st.ioMeta = ioIn;
        next_st.ioSync = st.ioMeta;
        next_st.vppMeta = vppPin;
        next_st.vppSync = st.vppMeta;
        next_st.pushValid = 1'b0;

        rise = st.sclkSync & ~st.sclkPrev;
        fall = ~st.sclkSync & st.sclkPrev;
        if (st.proto == PROTO_QUAD && st.accelHold) begin
            effProto = PROTO_EXT;
        end
        unique case (effProto)
            PROTO_DUAL: lanes = 4'h2;
            PROTO_QUAD: lanes = 4'h4;
            default: lanes = 4'h1;
        endcase

        // ------------------------------------------------------------------
        // apb: answer in the access cycle, data prepared during setup
        // ------------------------------------------------------------------
        if (psel && !penable) begin
            next_st.pslverr = 1'b0;
            next_st.prdata = 32'h0000_0000;
            unique case (paddr)
                REG_NVCFG: next_st.prdata = {16'h0000, st.nvcfg};
                REG_CTRL: next_st.prdata = 32'h0000_0000;
                REG_STATUS: begin
                    next_st.prdata[ST_PROTO_LSB +: 2] = st.proto;
                    next_st.prdata[ST_BUSY_BIT] = st.busy;
                    next_st.prdata[ST_WEL_BIT] = st.wel;
                    next_st.prdata[ST_VOLSEL_BIT] = st.volSel;
                    next_st.prdata[ST_ACCEL_BIT] = st.accelHold;
                    next_st.prdata[ST_OVERRUN_BIT] = st.overrun;
                    next_st.prdata[ST_EFF_LSB +: 2] = effProto;
                    next_st.prdata[ST_EVCFG_LSB +: 8] = st.evcfg;
                    next_st.pslverr = pwrite;
                end
                default: next_st.pslverr = 1'b1;
            endcase
        end
        if (psel && penable && pwrite) begin
            if (paddr == REG_NVCFG) begin
                next_st.nvcfg = pwdata[15:0];
            end else if (paddr == REG_CTRL) begin
                if (pwdata[CTRL_BOOT_BIT]) begin
                    // boot reload wipes any volatile choice
                    next_st.proto = nvProto(st.nvcfg);
                    next_st.volSel = 1'b0;
                    next_st.evcfg = EVCFG_RESET;
                    next_st.wel = 1'b0;
                end
                if (pwdata[CTRL_CLR_OVR_BIT]) begin
                    next_st.overrun = 1'b0;
                end
            end
        end

        // ------------------------------------------------------------------
        // busy timer and accelerated-supply fallback
        // ------------------------------------------------------------------
        if (st.busy) begin
            if (st.busyCnt != 16'h0000) begin
                next_st.busyCnt = st.busyCnt - 16'h0001;
            end else if (!progValid) begin
                next_st.busy = 1'b0;
            end
        end
        if (!st.vppSync) begin
            next_st.accelHold = 1'b0;
        end
        // set wins over a same-cycle software clear
        if (st.pushValid && !fifoInReady) begin
            next_st.overrun = 1'b1;
        end

        // ------------------------------------------------------------------
        // serial engine
        // ------------------------------------------------------------------
        if (st.selSync) begin
            next_st.phase = PH_CMD;
            next_st.bitCnt = 4'h0;
            next_st.byteCnt = 4'h0;
            next_st.rescueCnt = 4'h0;
            next_st.ioDriveN = 4'hf;
            if (st.workPend) begin
                next_st.workPend = 1'b0;
                next_st.busy = 1'b1;
                next_st.busyCnt = 16'(BUSY_CYCLES);
                next_st.wel = 1'b0;
                next_st.accelHold = st.vppSync & (st.proto == PROTO_QUAD);
            end
        end else begin
            if (rise) begin
                // rescue: eight ones on line 0 from select, in any protocol
                if (st.rescueCnt < RESCUE_ONES) begin
                    next_st.rescueCnt = st.ioSync[0] ? st.rescueCnt + 4'h1 : RESCUE_FAIL;
                    if (st.ioSync[0] && st.rescueCnt == RESCUE_ONES - 4'h1) begin
                        next_st.proto = PROTO_EXT;
                        next_st.volSel = 1'b0;
                        next_st.evcfg = EVCFG_RESET;
                    end
                end
                unique case (lanes)
                    4'h2: inByte = {st.shiftIn[5:0], st.ioSync[1:0]};
                    4'h4: inByte = {st.shiftIn[3:0], st.ioSync[3:0]};
                    default: inByte = {st.shiftIn[6:0], st.ioSync[0]};
                endcase
                next_st.shiftIn = inByte;
                if (st.bitCnt + lanes >= 4'h8) begin
                    next_st.bitCnt = 4'h0;
                    doneByte = 1'b1;
                end else begin
                    next_st.bitCnt = st.bitCnt + lanes;
                end
            end
            if (doneByte) begin
                unique case (st.phase)
                    PH_CMD: begin
                        next_st.cmd = inByte;
                        next_st.byteCnt = 4'h0;
                        next_st.phase = PH_IGNORE;
                        unique case (inByte)
                            CMD_WRITE_ENABLE: next_st.wel = ~st.busy;
                            CMD_READ_STATUS, CMD_READ_FLAGS, CMD_READ_EVCFG: begin
                                next_st.phase = PH_OUT;
                                next_st.cmd = inByte;
                                next_st.outShift = readSource(next_st);
                                next_st.outCnt = 4'h0;
                            end
                            CMD_WRITE_EVCFG, CMD_WRITE_NVCFG, CMD_PROGRAM, CMD_ERASE: begin
                                if (st.wel && !st.busy) begin
                                    next_st.phase = PH_ARG;
                                end
                            end
                            default: next_st.phase = PH_IGNORE;
                        endcase
                    end
                    PH_ARG: begin
                        next_st.byteCnt = st.byteCnt + 4'h1;
                        unique case (st.cmd)
                            CMD_WRITE_EVCFG: begin
                                // volatile write acts on the very next bit
                                next_st.evcfg = inByte;
                                next_st.proto = evProto(inByte);
                                next_st.volSel = 1'b1;
                                next_st.wel = 1'b0;
                                next_st.phase = PH_IGNORE;
                            end
                            CMD_WRITE_NVCFG: begin
                                if (st.byteCnt == 4'h0) begin
                                    next_st.nvLow = inByte;
                                end else begin
                                    // stored only; protocol follows it at next boot
                                    next_st.nvcfg = {inByte, st.nvLow};
                                    next_st.workPend = 1'b1;
                                    next_st.phase = PH_IGNORE;
                                end
                            end
                            CMD_ERASE: begin
                                if (st.byteCnt == ADDR_BYTES - 4'h1) begin
                                    next_st.workPend = 1'b1;
                                    next_st.phase = PH_IGNORE;
                                end
                            end
                            default: begin
                                if (st.byteCnt == ADDR_BYTES - 4'h1) begin
                                    next_st.workPend = 1'b1;
                                    next_st.phase = PH_DATA;
                                end
                            end
                        endcase
                    end
                    PH_DATA: begin
                        // no way to stall the host; a full fifo loses the byte
                        next_st.pushValid = 1'b1;
                        next_st.pushData = inByte;
                    end
                    default: next_st.phase = st.phase;
                endcase
            end
            if (fall && st.phase == PH_OUT) begin
                unique case (lanes)
                    4'h2: begin
                        next_st.ioOut = {2'b00, st.outShift[7:6]};
                        next_st.ioDriveN = 4'b1100;
                    end
                    4'h4: begin
                        next_st.ioOut = st.outShift[7:4];
                        next_st.ioDriveN = 4'b0000;
                    end
                    default: begin
                        next_st.ioOut = {2'b00, st.outShift[7], 1'b0};
                        next_st.ioDriveN = 4'b1101;
                    end
                endcase
                if (st.outCnt + lanes >= 4'h8) begin
                    // status bytes repeat live while the clock keeps running
                    next_st.outShift = readSource(st);
                    next_st.outCnt = 4'h0;
                end else begin
                    next_st.outShift = st.outShift << lanes;
                    next_st.outCnt = st.outCnt + lanes;
                end
            end
        end
    end

    // ----------------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st <= '0;
            st.selMeta <= 1'b1;
            st.selSync <= 1'b1;
            st.ioDriveN <= 4'hf;
            st.evcfg <= EVCFG_RESET;
            st.nvcfg <= NVCFG_RESET;
            st.proto <= PROTO_EXT;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------------
    // program data buffer
    // ----------------------------------------------------------------------
    byte_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) dataBuf (
        .clk(clk),
        .nrst(nrst),
        .inValid(st.pushValid),
        .inReady(fifoInReady),
        .inData(st.pushData),
        .outValid(progValid),
        .outReady(progReady),
        .outData(progData)
    );

    assign prdata = st.prdata;
    assign pready = 1'b1;
    assign pslverr = st.pslverr;
    assign ioOut = st.ioOut;
    assign ioDriveN = st.ioDriveN;
endmodule // flash_front

/* File: verification/flash_front_assertions.sv */
// port checker for the flash serial front end
// assumes a bind onto flash_front from the bench top file
`timescale 1ns/1ps
module flash_front_assertions
    import flash_front_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sclkPin,
    input wire logic selectN,
    input wire logic [3:0] ioOut,
    input wire logic [3:0] ioDriveN,
    input wire logic [DATA_W-1:0] progData,
    input wire logic progValid,
    input wire logic progReady
);
    // ----------------
    // edge age counters
    // ----------------
    // saturating, so a long idle never wraps into a false match
    logic [7:0] fallAge, riseAge;
    always_ff @(posedge clk) begin
        fallAge <= $fell(sclkPin) ? 8'h0 : fallAge + 8'(fallAge != 8'hff);
        riseAge <= $rose(sclkPin) ? 8'h0 : riseAge + 8'(riseAge != 8'hff);
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    line_release_a: assert property (selectN [*6] |-> ioDriveN == 4'hf)
        else $error("data lines driven while deselected");
    drive_shape_a: assert property (ioDriveN inside {4'hf, 4'hd, 4'hc, 4'h0})
        else $error("illegal drive pattern");
    out_on_fall_a: assert property ((ioDriveN != 4'hf) && $stable(ioDriveN)
        && $changed(ioOut) |-> fallAge <= 8'h8)
        else $error("output changed away from a falling serial edge");
    in_on_rise_a: assert property ($rose(progValid) |-> riseAge <= 8'h8)
        else $error("byte taken away from a rising serial edge");
    reset_idle_a: assert property ($rose(nrst) |-> ioDriveN == 4'hf && !progValid && prdata == 0)
        else $error("outputs not idle after reset");
    bad_addr_a: assert property (psel && penable && paddr > REG_STATUS |-> pslverr && prdata == 0)
        else $error("unmapped access not refused");
    status_ro_a: assert property (psel && penable && pwrite && paddr == REG_STATUS |-> pslverr)
        else $error("status write not refused");
    read_hold_a: assert property (psel && penable && pready ##1 !psel |-> $stable(prdata))
        else $error("read data moved before next setup");
    fifo_hold_a: assert property (progValid && !progReady |=> progValid && $stable(progData))
        else $error("fifo head changed while stalled");
    cover property (ioDriveN == 4'h0);
    cover property ($rose(progValid));
    cover property (psel && penable && pslverr);
endmodule // flash_front_assertions

/* File: verification/spi_host_model.sv */
// serial bus master model for the flash front end
// assumes its own 32 ns serial clock, unrelated in phase to clk
`timescale 1ns/1ps
module spi_host_model (
    output logic sclkPin,
    output logic selectN,
    output logic [3:0] ioIn,
    input wire logic [3:0] ioOut,
    input wire logic [3:0] ioDriveN
);
    logic [3:0] drv;
    wire [3:0] ln = ioOut ^ ioDriveN;
    initial begin
        sclkPin = 0;
        selectN = 1;
        ioIn = 4'h5;
    end
    // released lines toggle so a stale value is never read as data
    task automatic frame(input int w, input bit m3, input logic [7:0] tx[$], input int nrd,
            output logic [7:0] rx[$]);
        logic [7:0] b;
        rx = {};
        #1.5 sclkPin = m3;
        #16 selectN = 0;
        foreach (tx[i]) begin
            for (int k = 8 - w; k >= 0; k -= w) begin
                #16 sclkPin = 0;
                ioIn = w == 4 ? tx[i][k+:4] : w == 2 ? {~ioIn[3:2], tx[i][k+:2]}
                    : {~ioIn[3:1], tx[i][k]};
                #16 sclkPin = 1;
            end
        end
        repeat (nrd) begin
            for (int k = 0; k < 8; k += w) begin
                #16 sclkPin = 0;
                ioIn = ~ioIn;
                #16 sclkPin = 1;
                b = (b << w) | 8'(w == 4 ? ln : w == 2 ? ln & 4'h3 : ln[1]);
                drv = ioDriveN;
            end
            rx.push_back(b);
        end
        #16 sclkPin = m3;
        #16 selectN = 1;
        ioIn = ~ioIn;
        #40;
    endtask
endmodule // spi_host_model

/* File: verification/flash_front_test.sv */
// self-checking bench for the flash serial front end
// assumes the host model owns the serial pins; apb is driven here
`timescale 1ns/1ps
module flash_front_test
    import flash_front_pkg::*;
;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, sclkPin, selectN;
    logic vppPin, progValid, progReady, e;
    logic [7:0] paddr, progData, ev;
    logic [7:0] rx[$], tx[$], q[$];
    logic [31:0] pwdata, prdata, r;
    logic [31:0] lf = 32'h4bf9;
    logic [3:0] ioIn, ioOut, ioDriveN;
    int n_fail, n_tests, cyc, w;
    flash_front dut (.*);
    spi_host_model host (.*);
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) if (++cyc == 30000) begin
        n_fail++;
        print_verdict();
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(string n, logic [31:0] s, logic [31:0] x);
        n_tests++;
        if (s !== x) begin
            $display("MISMATCH %s expected %h seen %h", n, x, s);
            n_fail++;
        end
    endtask
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic st(logic [31:0] m, logic [31:0] x);
        apb(0, REG_STATUS, 0);
        chk("status", r & m, x);
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ----------------
    // main sequence
    // ----------------
    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata, progReady} = '0;
        vppPin = 0;
        repeat (4) @(posedge clk);
        nrst <= 1;
        st(32'hffffffff, 32'h00ff0000);
        apb(0, REG_NVCFG, 0);
        chk("nvcfg", r, 32'hffff);
        apb(0, 8'h0c, 0);
        chk("unmapped", e, 1);
        apb(1, REG_STATUS, 0);
        chk("ro", e, 1);
        w = 1;
        for (int m = 0; m < 2; m++) begin
            for (int p = 0; p < 3; p++) begin
                ev = p == 0 ? 8'hff : p == 1 ? 8'hbf : 8'h7f;
                host.frame(w, m, '{CMD_WRITE_ENABLE}, 0, rx);
                host.frame(w, m, '{CMD_READ_STATUS}, 1, rx);
                chk("wel", rx[0], 8'h02);
                host.frame(w, m, '{CMD_WRITE_EVCFG, ev}, 0, rx);
                w = 1 << p;
                host.frame(w, m, '{CMD_READ_EVCFG}, 1, rx);
                chk("evcfg", rx[0], ev);
                chk("drive", host.drv, p == 0 ? 4'hd : p == 1 ? 4'hc : 4'h0);
                st(32'h313, (p << 8) | 32'h10 | p);
            end
            $display("clock mode %0d done", m);
        end
        host.frame(1, 0, '{8'hff}, 0, rx);
        st(32'hff0303, 32'hff0000);
        apb(1, REG_NVCFG, 32'hfffb);
        apb(1, REG_CTRL, 32'h1);
        st(32'h313, 32'h101);
        host.frame(2, 0, '{CMD_WRITE_ENABLE}, 0, rx);
        host.frame(2, 0, '{CMD_WRITE_EVCFG, 8'h7f}, 0, rx);
        st(32'h313, 32'h212);
        host.frame(4, 0, '{CMD_WRITE_ENABLE}, 0, rx);
        host.frame(4, 0, '{CMD_WRITE_NVCFG, 8'hf7, 8'hff}, 0, rx);
        st(32'h4, 32'h4);
        repeat (BUSY_CYCLES) @(posedge clk);
        apb(1, REG_CTRL, 32'h1);
        st(32'h313, 32'h202);
        $display("boot selection done");
        vppPin <= 1;
        host.frame(4, 0, '{CMD_WRITE_ENABLE}, 0, rx);
        tx = '{CMD_PROGRAM, 8'h00, 8'h01, 8'h02};
        repeat (5) begin
            lf = lfsr(lf);
            tx.push_back(lf[7:0]);
            if (q.size() < FIFO_DEPTH) q.push_back(lf[7:0]);
        end
        host.frame(4, 0, tx, 0, rx);
        host.frame(1, 0, '{CMD_READ_STATUS}, 1, rx);
        chk("busy", rx[0], 8'h01);
        st(32'h363, 32'h62);
        chk("head", progData, q[0]);
        vppPin <= 0;
        repeat (3) @(posedge clk);
        st(32'h323, 32'h202);
        while (q.size() > 0) begin
            @(posedge clk);
            if (progValid === 1'b1 && progReady) chk("prog", progData, q.pop_front());
            lf = lfsr(lf);
            progReady <= lf[0];
        end
        progReady <= 1;
        apb(1, REG_CTRL, 32'h2);
        repeat (BUSY_CYCLES) @(posedge clk);
        host.frame(4, 0, '{CMD_READ_STATUS}, 1, rx);
        chk("ready", rx[0], 8'h00);
        st(32'h40, 32'h0);
        $display("program path done");
        print_verdict();
    end
endmodule // flash_front_test

bind flash_front flash_front_assertions ports_chk (.*);
